/* hw/watchdog_pkg.sv */
// Purpose: shared constants and types of the watchdog timer
// Assumes: 40 MHz system clock that is also the high-frequency clock
// Notes:   register indexes count words, so byte address = 4 * index
`default_nettype none

package watchdog_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int              ADR_W         = 10;
   localparam logic [7:0]      CONFIG_INDEX  = 8'h34;
   localparam logic [7:0]      COMMAND_INDEX = 8'h35;
   localparam logic [7:0]      STATUS_INDEX  = 8'h36;
   localparam logic [ADR_W-1:0] CONFIG_ADDR  = {CONFIG_INDEX, 2'b00};
   localparam logic [ADR_W-1:0] COMMAND_ADDR = {COMMAND_INDEX, 2'b00};
   localparam logic [ADR_W-1:0] STATUS_ADDR  = {STATUS_INDEX, 2'b00};

   // command codes
   localparam logic [7:0]      CMD_CLEAR     = 8'h4E;
   localparam logic [7:0]      CMD_DISABLE   = 8'hB1;

   // config field positions and reset value (enable, time 00, reset request)
   localparam int              ENABLE_POS    = 3;
   localparam int              TIME_LSB      = 1;
   localparam int              ACTION_POS    = 0;
   localparam logic [3:0]      CONFIG_RESET  = 4'h9;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int              CLK_PERIOD_NS = 25;
   localparam int              RESET_MAX_NS  = 600;
   // longest time rounds down
   localparam int              RESET_CYCLES  = RESET_MAX_NS / CLK_PERIOD_NS;
   // detection time exponent for code 00; binary counter spans two bits
   localparam int              DETECT_EXP0   = 25;
   localparam int              BIN_STAGES    = 2;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic       guard_enable_bit;
      logic [1:0] detection_time_sel;
      logic       overflow_action_sel;
   } config_type;

   typedef struct packed {
      logic       nmi_pending;
      logic [1:0] bin_count;
      logic       guard_enable_bit;
      logic [1:0] detection_time_sel;
      logic       overflow_action_sel;
      logic       running;
   } status_type;

   // gray codes along run -> frozen -> off
   typedef enum logic [1:0] {
      GUARD_RUN    = 2'b00,
      GUARD_FROZEN = 2'b01,
      GUARD_OFF    = 2'b11
   } guard_state_type;

   // exponent of the divider tick period: detection exponent less the stages
   function automatic logic [4:0] tick_exp(input logic [1:0] code, input logic dv1, input int exp0);
      tick_exp = 5'(exp0 - BIN_STAGES - 2 * int'(code) + int'(dv1));
   endfunction

   // full word address match
   function automatic logic addr_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] target);
      addr_hit = (adr == target);
   endfunction

endpackage

`default_nettype wire

/* hw/guard_prescaler.sv */
// Purpose: free-running internal divider feeding the binary counter
// Assumes: tap_exp below DIV_W
// Notes:   never cleared by software, which is why overflow may come early
`default_nettype none

module guard_prescaler #(
   parameter int DIV_W = 25
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       count_en,
   input  wire logic [4:0] tap_exp,
   output logic            tick
);

   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] tap_mask;

   ////////////////////////////////////////////////////////////////////////////
   // tick once every 2^tap_exp enabled cycles
   assign tap_mask = (DIV_W'(1) << tap_exp) - DIV_W'(1);
   assign tick     = count_en && ((div_reg & tap_mask) == tap_mask);

   // divider holds while frozen
   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_reg <= '0;
      end else if (count_en) begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end

endmodule

`default_nettype wire

/* hw/guard_reset_stretch.sv */
// Purpose: stretches an overflow pulse into the internal reset request
// Assumes: trigger is a one-cycle pulse on clk
// Notes:   length is exactly CYCLES clocks, a retrigger restarts it
`default_nettype none

module guard_reset_stretch #(
   parameter int CYCLES = 24
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic trigger,
   output logic      active
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          active_reg;

   ////////////////////////////////////////////////////////////////////////////
   // down counter, loaded on trigger
   always_comb begin
      if (trigger) begin
         cnt_next = CW'(CYCLES);
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - CW'(1);
      end else begin
         cnt_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg    <= '0;
         active_reg <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         active_reg <= (cnt_next != '0);
      end
   end

   assign active = active_reg;

endmodule

`default_nettype wire

/* hw/watchdog_timer.sv */
// Purpose: watchdog timer with divider, two-stage binary counter and
//          reset or non-maskable interrupt action on overflow
// Assumes: clk is the high-frequency clock; stop_mode (with warm-up),
//          idle_mode, clock_divider_sel and nmi_ack come from logic on clk
// Notes:   both documented registers are write only and read as zero;
//          a status word is provided for observation
//
// Operation
// - out of reset: enabled, time 00, reset action
// - overflow with action 1 requests internal reset
// - overflow with action 0 raises watchdog interrupt
// - counting freezes in stop and idle modes
// - clear code 4EH clears binary counter only
// - time code picks 2^25/23/21/19, doubled by divider
// - action select to interrupt is one-way until reset
// - both registers write only, never read-modify-write
// - command 4EH clears, B1H disables, others ignored
// - disable accepted only while enable bit is 0
// - binary counter held cleared while disabled
// - watchdog interrupt ignores the interrupt master flag
// - each new overflow interrupt is raised at once
// - overflow reset lasts at most 24 clock periods
`default_nettype none

module watchdog_timer #(
   parameter int DETECT_EXP0 = watchdog_pkg::DETECT_EXP0
) (
   input  wire logic                           clk,
   input  wire logic                           resetn,
   input  wire logic                           wb_cyc_i,
   input  wire logic                           wb_stb_i,
   input  wire logic                           wb_we_i,
   input  wire logic [3:0]                     wb_sel_i,
   input  wire logic [watchdog_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [31:0]                    wb_dat_i,
   output logic                                wb_ack_o,
   output logic      [31:0]                    wb_dat_o,
   input  wire logic                           stop_mode,
   input  wire logic                           idle_mode,
   input  wire logic                           clock_divider_sel,
   input  wire logic                           nmi_ack,
   output logic                                reset_request,
   output logic                                guard_overflow_irq,
   output logic                                nmi_pending
);

   import watchdog_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   // bus side
   logic            access;
   logic            ack_reg;
   logic            ack_next;
   logic            wr_take;
   logic [7:0]      wr_byte;
   logic [31:0]     rdata_reg;
   logic [31:0]     rdata_next;

   // decoded writes and commands
   logic            config_wr;
   logic            command_wr;
   logic            clear_cmd;
   logic            disable_cmd;

   // configuration and control state
   config_type      config_reg;
   config_type      config_next;
   guard_state_type state_reg;
   guard_state_type state_next;

   // counting chain
   logic            freeze;
   logic            div_tick;
   logic [4:0]      tap_exp;
   logic            advance;
   logic [1:0]      bin_reg;
   logic [1:0]      bin_next;
   logic            overflow;
   logic            ovf_reset;
   logic            ovf_irq;

   // interrupt outputs
   logic            irq_pulse_reg;
   logic            nmi_pending_reg;

   // observation
   status_type      status;

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave

   // one wait state: ack rises the cycle after the request, falls after one
   assign access   = wb_cyc_i & wb_stb_i;
   assign ack_next = access & ~ack_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
      end
   end

   // a write lands on the edge where the master sees ack
   assign wr_take    = access & wb_we_i & ack_reg & wb_sel_i[0];
   assign wr_byte    = wb_dat_i[7:0];
   assign config_wr  = wr_take & addr_hit(wb_adr_i, CONFIG_ADDR);
   assign command_wr = wr_take & addr_hit(wb_adr_i, COMMAND_ADDR);

   // command decode; any other code falls through with no effect
   assign clear_cmd   = command_wr & (wr_byte == CMD_CLEAR);
   assign disable_cmd = command_wr & (wr_byte == CMD_DISABLE)
                        & ~config_reg.guard_enable_bit;

   // read data: both control registers are write only and read as zero,
   // which keeps a read-modify-write from ever seeing meaningful bits
   always_comb begin
      rdata_next = 32'h00000000;
      if (addr_hit(wb_adr_i, STATUS_ADDR)) begin
         rdata_next = {24'h000000, status};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_reg <= 32'h00000000;
      end else if (ack_next && !wb_we_i) begin
         rdata_reg <= rdata_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // configuration register

   // the action select only ever falls; a later 1 is simply dropped
   always_comb begin
      config_next = config_reg;
      if (config_wr) begin
         config_next.guard_enable_bit    = wr_byte[ENABLE_POS];
         config_next.detection_time_sel  = wr_byte[TIME_LSB +: 2];
         config_next.overflow_action_sel = wr_byte[ACTION_POS]
                                           & config_reg.overflow_action_sel;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         config_reg <= config_type'(CONFIG_RESET);
      end else begin
         config_reg <= config_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run control

   // stop mode input is expected to cover the oscillator warm-up too
   assign freeze = stop_mode | idle_mode;

   // off only through the disable code; writing the enable bit restarts
   always_comb begin
      case (state_reg)
         GUARD_RUN: begin
            if (disable_cmd) begin
               state_next = GUARD_OFF;
            end else if (freeze) begin
               state_next = GUARD_FROZEN;
            end else begin
               state_next = GUARD_RUN;
            end
         end
         GUARD_FROZEN: begin
            if (disable_cmd) begin
               state_next = GUARD_OFF;
            end else if (!freeze) begin
               state_next = GUARD_RUN;
            end else begin
               state_next = GUARD_FROZEN;
            end
         end
         GUARD_OFF: begin
            if (config_wr && wr_byte[ENABLE_POS]) begin
               state_next = GUARD_RUN;
            end else begin
               state_next = GUARD_OFF;
            end
         end
         default: begin
            state_next = GUARD_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= GUARD_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // divider and binary counter

   // four divider ticks make one detection period
   assign tap_exp = tick_exp(config_reg.detection_time_sel, clock_divider_sel, DETECT_EXP0);

   // freeze acts combinationally so not a single count slips into stop mode
   guard_prescaler #(
      .DIV_W    (DETECT_EXP0)
   ) u_prescaler (
      .clk      (clk),
      .resetn   (resetn),
      .count_en (~freeze),
      .tap_exp  (tap_exp),
      .tick     (div_tick)
   );

   assign advance = div_tick & (state_reg != GUARD_OFF);

   // a clear or disable beats a coincident tick; the divider is untouched,
   // so the first overflow after a clear can come at three quarters time
   always_comb begin
      if (state_reg == GUARD_OFF || disable_cmd) begin
         bin_next = 2'b00;
      end else if (clear_cmd) begin
         bin_next = 2'b00;
      end else if (advance) begin
         bin_next = bin_reg + 2'b01;
      end else begin
         bin_next = bin_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         bin_reg <= 2'b00;
      end else begin
         bin_reg <= bin_next;
      end
   end

   // overflow when the top stage carries out
   assign overflow = advance & (bin_reg == 2'b11) & ~clear_cmd & ~disable_cmd;

   // routed by the select as it stands at the overflow
   assign ovf_reset = overflow & config_reg.overflow_action_sel;
   assign ovf_irq   = overflow & ~config_reg.overflow_action_sel;

   ////////////////////////////////////////////////////////////////////////////
   // reset request

   guard_reset_stretch #(
      .CYCLES  (RESET_CYCLES)
   ) u_reset_stretch (
      .clk     (clk),
      .resetn  (resetn),
      .trigger (ovf_reset),
      .active  (reset_request)
   );

   ////////////////////////////////////////////////////////////////////////////
   // non-maskable interrupt

   // no master-flag gate: every overflow fires a fresh pulse even while an
   // earlier one is still being serviced, so nesting depth is software's worry
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_pulse_reg <= 1'b0;
      end else begin
         irq_pulse_reg <= ovf_irq;
      end
   end

   // pending level: set wins over a coincident acknowledge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         nmi_pending_reg <= 1'b0;
      end else if (ovf_irq) begin
         nmi_pending_reg <= 1'b1;
      end else if (nmi_ack) begin
         nmi_pending_reg <= 1'b0;
      end
   end

   assign guard_overflow_irq = irq_pulse_reg;
   assign nmi_pending        = nmi_pending_reg;

   ////////////////////////////////////////////////////////////////////////////
   // status word

   always_comb begin
      status.nmi_pending         = nmi_pending_reg;
      status.bin_count           = bin_reg;
      status.guard_enable_bit    = config_reg.guard_enable_bit;
      status.detection_time_sel  = config_reg.detection_time_sel;
      status.overflow_action_sel = config_reg.overflow_action_sel;
      status.running             = (state_reg != GUARD_OFF);
   end

endmodule

`default_nettype wire

/* bench/watchdog_timer_monitor.sv */
// Purpose: port checker of the watchdog timer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every watchdog_timer instance
`default_nettype none

module watchdog_timer_monitor #(
   parameter int DETECT_EXP0 = 25
) (
   input wire logic                           clk,
   input wire logic                           resetn,
   input wire logic                           wb_cyc_i,
   input wire logic                           wb_stb_i,
   input wire logic                           wb_we_i,
   input wire logic [3:0]                     wb_sel_i,
   input wire logic [watchdog_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [31:0]                    wb_dat_i,
   input wire logic                           wb_ack_o,
   input wire logic [31:0]                    wb_dat_o,
   input wire logic                           stop_mode,
   input wire logic                           idle_mode,
   input wire logic                           clock_divider_sel,
   input wire logic                           nmi_ack,
   input wire logic                           reset_request,
   input wire logic                           guard_overflow_irq,
   input wire logic                           nmi_pending
);
   timeunit 1ns;
   timeprecision 100ps;
   import watchdog_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////
   logic [5:0] rr_cnt;
   logic       clr_wr;

   // run length of the reset request; wraps if stuck, the cap check fires first
   always_ff @(posedge clk) begin
      if (!resetn || !reset_request)
         rr_cnt <= 6'h00;
      else
         rr_cnt <= rr_cnt + 6'h01;
   end

   // clear code takes effect at the edge that sees ack
   assign clr_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == COMMAND_ADDR && wb_dat_i[7:0] == CMD_CLEAR;

   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered after one wait state");
   read_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i != STATUS_ADDR |-> wb_dat_o == 32'h0)
      else $error("write-only place read back nonzero");
   reset_cap_a: assert property (rr_cnt <= 6'h18)
      else $error("reset request longer than 24 cycles");
   reset_len_a: assert property ($fell(reset_request) |-> rr_cnt == 6'h18)
      else $error("reset request not 24 cycles long");
   irq_once_a: assert property (guard_overflow_irq |=> !guard_overflow_irq)
      else $error("interrupt pulse wider than one cycle");
   irq_pend_a: assert property (guard_overflow_irq |-> nmi_pending)
      else $error("interrupt raised without pending state");
   pend_ack_a: assert property (nmi_pending && nmi_ack |=> !nmi_pending || guard_overflow_irq)
      else $error("pending state survived its acknowledge");
   pend_keep_a: assert property (nmi_pending && !nmi_ack |=> nmi_pending)
      else $error("pending state lost without acknowledge");
   freeze_hold_a: assert property (stop_mode || idle_mode |=> !guard_overflow_irq && !$rose(reset_request))
      else $error("overflow while frozen");
   clear_wins_a: assert property (clr_wr |=> !guard_overflow_irq && !$rose(reset_request))
      else $error("overflow right after a clear");
   route_one_way_a: assert property (guard_overflow_irq |-> !$rose(reset_request))
      else $error("overflow sent both ways");
endmodule

bind watchdog_timer watchdog_timer_monitor #(.DETECT_EXP0(DETECT_EXP0)) mon (
   .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
   .stop_mode(stop_mode), .idle_mode(idle_mode), .clock_divider_sel(clock_divider_sel), .nmi_ack(nmi_ack),
   .reset_request(reset_request), .guard_overflow_irq(guard_overflow_irq), .nmi_pending(nmi_pending));

`default_nettype wire

/* bench/tb_watchdog_timer.sv */
// Purpose: self-checking bench of the watchdog timer
// Assumes: DETECT_EXP0 cut to 8, so periods run 2^9 down to 2^2 cycles
// Notes:   the interrupt action is one-way, so reset-action tests come first
`default_nettype none

module tb_watchdog_timer;
   timeunit 1ns;
   timeprecision 100ps;
   import watchdog_pkg::*;

   localparam int    EXP0 = 8;
   logic             clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic             stop_mode, idle_mode, clock_divider_sel, nmi_ack;
   logic             reset_request, guard_overflow_irq, nmi_pending;
   logic [3:0]       wb_sel_i;
   logic [ADR_W-1:0] wb_adr_i;
   logic [31:0]      wb_dat_i, wb_dat_o, q, r, rng;
   int               fails, cmp_count, k, cyc_n, ev_cnt, ev_t, ev_gap, irqs, rr_run, rr_last;

   watchdog_timer #(.DETECT_EXP0(EXP0)) dut (
      .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .stop_mode(stop_mode), .idle_mode(idle_mode),
      .clock_divider_sel(clock_divider_sel), .nmi_ack(nmi_ack), .reset_request(reset_request),
      .guard_overflow_irq(guard_overflow_irq), .nmi_pending(nmi_pending));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////
   // overflow events of either kind, their spacing and the reset length
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      rr_run <= (reset_request === 1'b1) ? rr_run + 1 : 0;
      if (reset_request !== 1'b1 && rr_run != 0)
         rr_last <= rr_run;
      if (guard_overflow_irq === 1'b1 || (reset_request === 1'b1 && rr_run == 0)) begin
         ev_cnt <= ev_cnt + 1;
         ev_gap <= cyc_n - ev_t;
         ev_t <= cyc_n;
         irqs <= irqs + int'(guard_overflow_irq === 1'b1);
      end
   end

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // full period in cycles for a time code and divider select
   function automatic int period(input int c, input int dv);
      return 1 << (EXP0 - 2 * c + dv);
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // one classic cycle; ack is sampled on the rising edge, then released
   task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= s;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         fails++;
         tally_and_finish();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // clear on both sides so a stale count cannot fire under the new period;
   // clears come from the main flow only, never from an interrupt handler
   task automatic cfg(input logic [7:0] d);
      bus(1'b1, COMMAND_ADDR, CMD_CLEAR, 4'hF);
      bus(1'b1, CONFIG_ADDR, d, 4'hF);
      bus(1'b1, COMMAND_ADDR, CMD_CLEAR, 4'hF);
   endtask

   task automatic await_ev(input int bound);
      int k0, n;
      k0 = ev_cnt;
      n = 0;
      while (ev_cnt == k0 && n < bound) begin
         @(posedge clk);
         n++;
      end
      if (ev_cnt == k0) begin
         fails++;
         tally_and_finish();
      end
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      rng = 32'h0000F727;
      {resetn, wb_cyc_i, wb_stb_i, wb_we_i, stop_mode, idle_mode, clock_divider_sel, nmi_ack} = 8'h00;
      wb_sel_i = 4'h0;
      wb_adr_i = '0;
      wb_dat_i = 32'h0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      r = xs();
      bus(1'b1, {2'b11, r[5:0], 2'b00}, r[15:8], 4'hF);
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, i == 0 ? CONFIG_ADDR : i == 1 ? COMMAND_ADDR : {2'b11, r[5:0], 2'b00}, 8'h00, 4'hF);
         check(q, 32'h0);
      end
      bus(1'b0, STATUS_ADDR, 8'h00, 4'hF);
      check(q[4:0], 5'h13);
      await_ev(600);
      await_ev(600);
      check(ev_gap, period(0, 0));
      check(irqs, 0);
      repeat (30) @(posedge clk);
      check(rr_last, 24);
      $display("test reset action done");
      cfg(8'h0B);
      k = ev_cnt;
      repeat (8) begin
         repeat (36) @(posedge clk);
         bus(1'b1, COMMAND_ADDR, CMD_CLEAR, 4'hF);
      end
      check(ev_cnt, k);
      // random codes must not clear, so overflow still comes
      repeat (8) begin
         r = xs();
         if (r[7:0] == CMD_CLEAR || r[7:0] == CMD_DISABLE)
            r[7:0] = 8'h00;
         bus(1'b1, COMMAND_ADDR, r[7:0], 4'hF);
         repeat (20) @(posedge clk);
      end
      check(ev_cnt > k, 1'b1);
      $display("test clear and codes done");
      cfg(8'h0B);
      k = ev_cnt;
      idle_mode <= 1'b1;
      repeat (150) @(posedge clk);
      // clear just before stop and again right after it, as software must
      bus(1'b1, COMMAND_ADDR, CMD_CLEAR, 4'hF);
      idle_mode <= 1'b0;
      stop_mode <= 1'b1;
      repeat (150) @(posedge clk);
      stop_mode <= 1'b0;
      check(ev_cnt, k);
      bus(1'b1, COMMAND_ADDR, CMD_CLEAR, 4'hF);
      await_ev(70);
      $display("test freeze done");
      // enable cleared with sel low is ignored, so disable must be refused
      bus(1'b1, CONFIG_ADDR, 8'h03, 4'hE);
      bus(1'b1, COMMAND_ADDR, CMD_DISABLE, 4'hF);
      bus(1'b0, STATUS_ADDR, 8'h00, 4'hF);
      check(q[0], 1'b1);
      // stop sequence: clear, enable bit 0, clear, then the disable code
      cfg(8'h03);
      bus(1'b1, COMMAND_ADDR, CMD_DISABLE, 4'hF);
      k = ev_cnt;
      repeat (300) @(posedge clk);
      bus(1'b0, STATUS_ADDR, 8'h00, 4'hF);
      check({q[6:5], q[0]}, 3'h0);
      check(ev_cnt, k);
      $display("test disable done");
      for (int dv = 0; dv < 2; dv++) begin
         for (int c = 0; c < 4; c++) begin
            clock_divider_sel <= dv[0];
            // no handler stack exists here, so interrupt action is safe to pick
            cfg({4'h0, 1'b1, c[1:0], 1'b0});
            k = ev_cnt - irqs;
            await_ev(600);
            await_ev(600);
            check(ev_gap, period(c, dv));
            check(ev_cnt - irqs, k);
            check(nmi_pending, 1'b1);
         end
      end
      bus(1'b1, CONFIG_ADDR, 8'h09, 4'hF);
      bus(1'b0, STATUS_ADDR, 8'h00, 4'hF);
      check(q[1], 1'b0);
      // fresh clear so no stale overflow lands on the acknowledge below
      bus(1'b1, COMMAND_ADDR, CMD_CLEAR, 4'hF);
      nmi_ack <= 1'b1;
      @(posedge clk);
      nmi_ack <= 1'b0;
      @(posedge clk);
      check(nmi_pending, 1'b0);
      $display("test interrupt action done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
